// [dram_mode_regs.vh]
/*
 * constants for the device control mode register decoder: mode register
 * address, field positions, reset value and refresh-rate status codes.
 * assumes it is included once per compilation unit by its bare name.
 */
// Summary of operation
// RULE_01 - writing training flag one enters training
// RULE_02 - training with cke low: ignore commands, echo ca
// RULE_03 - controller raises cke before clearing training flag
// RULE_04 - vref output shows only operating set point
// RULE_05 - vref output enable in bit two
// RULE_06 - fast response bit selects high-current vref generator
// RULE_07 - refresh option valid only when feature bit set
// RULE_08 - option zero disables status codes 001, 010
// RULE_09 - option zero reports 011 instead
// RULE_10 - controller follows reported refresh status code
// RULE_11 - self refresh compensation ignores refresh option
// RULE_12 - data mask disable zero keeps masking on
// RULE_13 - no masked writes while masking disabled
// RULE_14 - write select picks set point for vref writes
// RULE_15 - operate select picks governing set point
// RULE_16 - training flag resets to zero
// RULE_17 - one write sets all fields; reset restores
`ifndef DRAM_MODE_REGS_VH
`define DRAM_MODE_REGS_VH

`define MODE_REG_ADDR     6'h0D
`define VREF_DQ_ADDR      6'h0E
`define VREF_CA_ADDR      6'h0C
`define MODE_REG_RESET    8'h00
`define FLD_TRAINING      0
`define FLD_PREAMBLE      1
`define FLD_VREF_OUT      2
`define FLD_FAST_RESP     3
`define FLD_RATE_OPT      4
`define FLD_MASK_OFF      5
`define FLD_WR_SEL        6
`define FLD_OP_SEL        7
`define DQ_VREF_CA_LO     0
`define DQ_VREF_DQ_LO     8
`define RATE_STATUS_RESET 3'h0
`define RATE_CODE_1X_LOW  3'h1
`define RATE_CODE_2X_LOW  3'h2
`define RATE_CODE_SUB     3'h3
`define VREF_DQ_RESET     7'h5D
`define VREF_CA_RESET     7'h5D

`endif

// [refresh_rate_filter.v]
/*
 * refresh-rate status code filter: replaces the two slow codes with the
 * substitute code when the refresh option is off and the feature allows it.
 * assumes the raw code comes from the temperature sensor logic.
 */
`include "dram_mode_regs.vh"

module refresh_rate_filter (
   input  wire       i_feature_rro_valid,
   input  wire       i_refresh_rate_option,
   input  wire [2:0] i_raw_code,
   output reg  [2:0] o_code
);
   always @* begin
      o_code = i_raw_code;
      if (i_feature_rro_valid && !i_refresh_rate_option) begin // RULE_07
         if (i_raw_code == `RATE_CODE_1X_LOW ||
             i_raw_code == `RATE_CODE_2X_LOW) begin // RULE_08
            o_code = `RATE_CODE_SUB; // RULE_09
         end
      end
   end
endmodule

// [set_point_bank.v]
/*
 * two-set-point storage for one vref setting/range register.
 * assumes writes arrive as a one-cycle strobe with data on the clock.
 */
`include "dram_mode_regs.vh"

module set_point_bank #(
   parameter       WIDTH = 7,
   parameter [6:0] RESET = `VREF_DQ_RESET
) (
   input  wire             i_ref_clk,
   input  wire             i_rst_b,
   input  wire             i_ce,
   input  wire             i_wr,
   input  wire             i_wr_sel,
   input  wire             i_op_sel,
   input  wire [WIDTH-1:0] i_data,
   output wire [WIDTH-1:0] o_active,
   output wire [WIDTH-1:0] o_selected
);
   reg [WIDTH-1:0] point [0:1];

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_pt
         localparam [0:0] IDX = g;
         always @(posedge i_ref_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
               point[g] <= RESET[WIDTH-1:0];
            end else if (i_ce && i_wr && (i_wr_sel == IDX)) begin // RULE_14
               point[g] <= i_data;
            end
         end
      end
   endgenerate

   assign o_active   = point[i_op_sel]; // RULE_15
   assign o_selected = point[i_wr_sel];
endmodule

// [dram_control_mode_register.v]
/*
 * device control mode register decoder: captures mode register writes,
 * drives mode controls, command bus training echo, vref output and the
 * set-point banks for the vref setting registers.
 * assumes writes and cke are synchronous to i_ref_clk, already decoded
 * from the command/address bus into a one-cycle write strobe.
 */
`include "dram_mode_regs.vh"

module dram_control_mode_register #(
   parameter CA_WIDTH = 6,
   parameter DQ_WIDTH = 16
) (
   input  wire                i_ref_clk,
   input  wire                i_rst_b,
   input  wire                i_ce,
   input  wire                i_mrw,
   input  wire [5:0]          i_mrw_addr,
   input  wire [7:0]          i_mrw_data,
   input  wire                i_cke,
   input  wire [CA_WIDTH-1:0] i_ca,
   input  wire                i_cmd_valid,
   input  wire                i_feature_rro_valid,
   input  wire [2:0]          i_raw_rate_code,
   input  wire                i_temp_self_refresh,
   output reg  [DQ_WIDTH-1:0] o_dq,
   output reg                 o_dq_oe,
   output wire                o_cmd_enable,
   output wire                o_training_mode,
   output wire                o_read_preamble_train,
   output wire                o_vref_fast_response,
   output wire                o_data_mask_enable,
   output wire                o_set_point_write_select,
   output wire                o_set_point_operate_select,
   output reg  [2:0]          o_refresh_rate_status,
   output wire                o_temp_compensated_self_refresh,
   output wire [6:0]          o_vref_dq_active,
   output wire [6:0]          o_vref_ca_active
);
   ////////////////////////////////////////////////////////////////////////
   // the mode register itself
   reg  [7:0] device_control_mode_reg;
   wire       echo_ca;
   // every command, writes too, is dropped while the ca echo runs
   wire       mrw_taken = i_mrw && !echo_ca; // RULE_02
   wire       mode_wr   = mrw_taken && (i_mrw_addr == `MODE_REG_ADDR);

   always @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         device_control_mode_reg <= `MODE_REG_RESET; // RULE_16
      end else if (i_ce && mode_wr) begin
         // whole byte lands at once; fields hold until next write
         device_control_mode_reg <= i_mrw_data; // RULE_17
      end
   end

   wire command_bus_training_flag = device_control_mode_reg[`FLD_TRAINING];
   wire vref_output_enable        = device_control_mode_reg[`FLD_VREF_OUT];
   wire refresh_rate_option       = device_control_mode_reg[`FLD_RATE_OPT];
   wire data_mask_disable         = device_control_mode_reg[`FLD_MASK_OFF];
   wire set_point_write_select    = device_control_mode_reg[`FLD_WR_SEL];
   wire set_point_operate_select  = device_control_mode_reg[`FLD_OP_SEL];

   assign o_training_mode       = command_bus_training_flag; // RULE_01
   assign o_read_preamble_train = device_control_mode_reg[`FLD_PREAMBLE];
   // RULE_06
   assign o_vref_fast_response  = device_control_mode_reg[`FLD_FAST_RESP];
   assign o_data_mask_enable    = !data_mask_disable; // RULE_12
   assign o_set_point_write_select   = set_point_write_select;
   assign o_set_point_operate_select = set_point_operate_select;
   // self refresh compensation passes through untouched by the option
   assign o_temp_compensated_self_refresh = i_temp_self_refresh; // RULE_11

   ////////////////////////////////////////////////////////////////////////
   // command bus training: commands blocked while cke is low
   assign echo_ca      = command_bus_training_flag && !i_cke;
   // the clearing write needs cke high first, else it is dropped too
   assign o_cmd_enable = i_cmd_valid && !echo_ca; // RULE_02

   ////////////////////////////////////////////////////////////////////////
   // vref set-point storage
   wire [6:0] dq_sel;
   wire [6:0] ca_sel;

   set_point_bank #(
      .WIDTH (7),
      .RESET (`VREF_DQ_RESET)
   ) u_vref_dq (
      .i_ref_clk  (i_ref_clk),
      .i_rst_b    (i_rst_b),
      .i_ce       (i_ce),
      .i_wr       (mrw_taken && (i_mrw_addr == `VREF_DQ_ADDR)),
      .i_wr_sel   (set_point_write_select),
      .i_op_sel   (set_point_operate_select),
      .i_data     (i_mrw_data[6:0]),
      .o_active   (o_vref_dq_active),
      .o_selected (dq_sel)
   );

   set_point_bank #(
      .WIDTH (7),
      .RESET (`VREF_CA_RESET)
   ) u_vref_ca (
      .i_ref_clk  (i_ref_clk),
      .i_rst_b    (i_rst_b),
      .i_ce       (i_ce),
      .i_wr       (mrw_taken && (i_mrw_addr == `VREF_CA_ADDR)),
      .i_wr_sel   (set_point_write_select),
      .i_op_sel   (set_point_operate_select),
      .i_data     (i_mrw_data[6:0]),
      .o_active   (o_vref_ca_active),
      .o_selected (ca_sel)
   );

   ////////////////////////////////////////////////////////////////////////
   // data pins: training echo wins over vref output
   reg [DQ_WIDTH-1:0] next_dq;
   reg                next_dq_oe;

   always @* begin
      next_dq    = {DQ_WIDTH{1'b0}};
      next_dq_oe = 1'b0;
      if (echo_ca) begin
         next_dq[CA_WIDTH-1:0] = i_ca; // RULE_02
         next_dq_oe = 1'b1;
      end else if (vref_output_enable) begin // RULE_05
         // only the operating set point is shown, never the write target
         next_dq[`DQ_VREF_CA_LO +: 7] = o_vref_ca_active; // RULE_04
         next_dq[`DQ_VREF_DQ_LO +: 7] = o_vref_dq_active; // RULE_04
         next_dq_oe = 1'b1;
      end
   end

   always @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_dq    <= {DQ_WIDTH{1'b0}};
         o_dq_oe <= 1'b0;
      end else if (i_ce) begin
         o_dq    <= next_dq;
         o_dq_oe <= next_dq_oe;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // refresh-rate status as reported to the controller
   wire [2:0] rate_code;

   refresh_rate_filter u_rate (
      .i_feature_rro_valid   (i_feature_rro_valid),
      .i_refresh_rate_option (refresh_rate_option),
      .i_raw_code            (i_raw_rate_code),
      .o_code                (rate_code)
   );

   always @(posedge i_ref_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_refresh_rate_status <= `RATE_STATUS_RESET;
      end else if (i_ce) begin
         o_refresh_rate_status <= rate_code; // RULE_08
      end
   end
endmodule

// [dram_mode_chk_sva.sv]
/* port checker for dram_control_mode_register.
   assumes one clock domain; bound at the foot of this file. */
module dram_mode_chk #(
   parameter CA_WIDTH = 6,
   parameter DQ_WIDTH = 16
) (
   input wire                i_ref_clk,
   input wire                i_rst_b,
   input wire                i_ce,
   input wire                i_mrw,
   input wire [5:0]          i_mrw_addr,
   input wire [7:0]          i_mrw_data,
   input wire                i_cke,
   input wire [CA_WIDTH-1:0] i_ca,
   input wire [DQ_WIDTH-1:0] o_dq,
   input wire                o_dq_oe,
   input wire                o_cmd_enable,
   input wire                o_training_mode,
   input wire                o_set_point_write_select,
   input wire                o_set_point_operate_select
);
   timeunit 1ns;
   timeprecision 1ns;
   wire tr = o_training_mode && !i_cke;
   // writes that arrive during the ca echo are dropped by the device
   wire wr = i_ce && i_mrw && i_mrw_addr == 6'h0D && !tr;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);
////////////////////////////////////////
   property p_train; wr |=> o_training_mode == $past(i_mrw_data[0]); endproperty
   a_train: assert property (p_train) else $error("training flag");
   property p_wsel;
      wr |=> o_set_point_write_select == $past(i_mrw_data[6]);
   endproperty
   a_wsel: assert property (p_wsel) else $error("write select");
   property p_osel;
      wr |=> o_set_point_operate_select == $past(i_mrw_data[7]);
   endproperty
   a_osel: assert property (p_osel) else $error("operate select");
   property p_cmd; tr |-> !o_cmd_enable; endproperty
   a_cmd: assert property (p_cmd) else $error("command not ignored");
   property p_drop; tr && i_ce && i_mrw |=> o_training_mode; endproperty
   a_drop: assert property (p_drop) else $error("write taken in echo");
   property p_echo; tr && i_ce |=> o_dq[5:0] == $past(i_ca); endproperty
   a_echo: assert property (p_echo) else $error("ca echo");
   property p_oe; tr && i_ce |=> o_dq_oe; endproperty
   a_oe: assert property (p_oe) else $error("echo not driven");
   property p_hold;
      !wr |=> $stable({o_training_mode, o_set_point_write_select,
                       o_set_point_operate_select});
   endproperty
   a_hold: assert property (p_hold) else $error("field changed");
   property p_vout; wr && i_mrw_data[2:0] == 3'h4 ##1 !wr && i_ce |=> o_dq_oe;
   endproperty
   a_vout: assert property (p_vout) else $error("vref not output");
   cover property (tr ##1 o_dq_oe);
   cover property (o_set_point_operate_select);
   cover property (wr && i_mrw_data[6]);
endmodule

bind dram_control_mode_register dram_mode_chk #(
   .CA_WIDTH(CA_WIDTH), .DQ_WIDTH(DQ_WIDTH)) chk (
   .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_mrw(i_mrw),
   .i_mrw_addr(i_mrw_addr), .i_mrw_data(i_mrw_data), .i_cke(i_cke),
   .i_ca(i_ca), .o_dq(o_dq), .o_dq_oe(o_dq_oe), .o_cmd_enable(o_cmd_enable),
   .o_training_mode(o_training_mode),
   .o_set_point_write_select(o_set_point_write_select),
   .o_set_point_operate_select(o_set_point_operate_select));

// [lp_ctrl_model.sv]
/* memory controller model: mode register writes and cke.
   assumes its tasks are called just after a rising edge. */
module lp_ctrl_model (
   input  wire       i_ref_clk,
   output reg        o_mrw = 1'b0,
   output reg  [5:0] o_addr = 6'h00,
   output reg  [7:0] o_data = 8'h00,
   output reg        o_cke = 1'b1
);
   timeunit 1ns;
   timeprecision 1ns;
   // issues no masked writes at all
   task cke(input v);
      @(posedge i_ref_clk);
      o_cke <= v;
   endtask
   task mrw(input [5:0] a, input [7:0] d);
      @(posedge i_ref_clk);
      if (a == 6'h0D && !d[0]) begin
         o_cke <= 1'b1;
         @(posedge i_ref_clk);
      end
      o_mrw  <= 1'b1;
      o_addr <= a;
      o_data <= d;
      @(posedge i_ref_clk);
      o_mrw  <= 1'b0;
      o_addr <= ~a;
      o_data <= ~d;
   endtask
endmodule

// [dram_control_mode_register_test.sv]
/* self-checking bench for dram_control_mode_register.
   assumes lp_ctrl_model issues every write and drives cke. */
module dram_control_mode_register_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic       i_ref_clk = 1'b0;
   logic       i_rst_b = 1'b0;
   logic       i_ce = 1'b1;
   logic [5:0] i_ca = 6'h00;
   logic       i_feat = 1'b0;
   logic [2:0] i_raw = 3'h0;
   logic       i_tsr = 1'b0;
   logic       i_cmd = 1'b1;
   wire        mrw, cke, cmd_en, trn, fast, mask, wsel, osel, self_ref, oe;
   wire        pre;
   wire [6:0]  vca;
   wire [5:0]  addr;
   wire [7:0]  data;
   wire [15:0] dq;
   wire [2:0]  rate;
   wire [6:0]  vdq;
   int         n_errors = 0;
   int         compares = 0;
   int         k;
   always #25 i_ref_clk = ~i_ref_clk;
   lp_ctrl_model ctl (.i_ref_clk(i_ref_clk), .o_mrw(mrw), .o_addr(addr),
      .o_data(data), .o_cke(cke));
   dram_control_mode_register uut (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b),
      .i_ce(i_ce), .i_mrw(mrw), .i_mrw_addr(addr), .i_mrw_data(data),
      .i_cke(cke), .i_ca(i_ca), .i_cmd_valid(i_cmd),
      .i_feature_rro_valid(i_feat), .i_raw_rate_code(i_raw),
      .i_temp_self_refresh(i_tsr), .o_dq(dq), .o_dq_oe(oe),
      .o_cmd_enable(cmd_en), .o_training_mode(trn),
      .o_read_preamble_train(pre), .o_vref_fast_response(fast),
      .o_data_mask_enable(mask), .o_set_point_write_select(wsel),
      .o_set_point_operate_select(osel), .o_refresh_rate_status(rate),
      .o_temp_compensated_self_refresh(self_ref), .o_vref_dq_active(vdq),
      .o_vref_ca_active(vca));
////////////////////////////////////////
   task chk(input string n, input logic [15:0] s, e);
      compares++;
      if (s !== e) begin
         n_errors++;
         $display("mismatch %s exp %h seen %h", n, e, s);
      end
   endtask
   task step(input int c);
      repeat (c) @(posedge i_ref_clk);
      #1;
   endtask
   task wr(input [5:0] a, input [7:0] d);
      ctl.mrw(a, d);
      #1;
   endtask
   task report_and_stop;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
////////////////////////////////////////
   initial begin
      repeat (8) @(posedge i_ref_clk);
      i_rst_b <= 1'b1;
      step(1);
      chk("trn", trn, 0);
      chk("sel", {wsel, osel, mask}, 1);
      wr(6'h0D, 8'h01);
      chk("trn", trn, 1);
      ctl.cke(1'b0);
      i_ca <= 6'h2A;
      step(2);
      chk("echo", {cmd_en, oe, dq[5:0]}, 8'h6A);
      wr(6'h0D, 8'h81);
      chk("drop", {trn, osel}, 2);
      wr(6'h0D, 8'h00);
      chk("cmd", {trn, cmd_en}, 1);
      @(posedge i_ref_clk);
      i_ce <= 1'b0;
      wr(6'h0D, 8'hFF);
      chk("frozen", trn, 0);
      @(posedge i_ref_clk);
      i_ce <= 1'b1;
      wr(6'h0F, 8'hFF);
      chk("other", {trn, mask}, 1);
      wr(6'h0D, 8'h40);
      wr(6'h0E, 8'h12);
      chk("vdq", vdq, 7'h5D);
      wr(6'h0D, 8'hAC);
      chk("ctl", {osel, wsel, mask, fast}, 4'h9);
      chk("vdq", vdq, 7'h12);
      step(2);
      chk("vout", {oe, dq[14:8], dq[6:0]}, {8'h92, 7'h5D});
      @(posedge i_ref_clk);
      i_feat <= 1'b1;
      for (k = 0; k < 8; k++) begin
         @(posedge i_ref_clk);
         i_raw <= k[2:0];
         step(2);
         chk("rate", rate, (k == 1 || k == 2) ? 3'h3 : k[2:0]);
      end
      wr(6'h0D, 8'h10);
      @(posedge i_ref_clk);
      i_raw <= 3'h2;
      step(2);
      chk("rate", rate, 3'h2);
      wr(6'h0D, 8'h00);
      @(posedge i_ref_clk);
      i_feat <= 1'b0;
      i_tsr <= 1'b1;
      step(2);
      chk("rate", rate, 3'h2);
      chk("self_ref", self_ref, 1);
      wr(6'h0D, 8'h42);
      wr(6'h0C, 8'h21);
      chk("pre", pre, 1);
      chk("vca", vca, 7'h5D);
      wr(6'h0D, 8'h80);
      chk("vca", vca, 7'h21);
      @(posedge i_ref_clk);
      i_cmd <= 1'b0;
      step(1);
      chk("cmd", cmd_en, 0);
      @(posedge i_ref_clk);
      i_cmd <= 1'b1;
      i_rst_b <= 1'b0;
      step(1);
      chk("rst", {trn, osel, wsel, mask}, 1);
      chk("vca", vca, 7'h5D);
      @(posedge i_ref_clk);
      i_rst_b <= 1'b1;
      wr(6'h0D, 8'h01);
      chk("trn", trn, 1);
      report_and_stop();
   end
   // whole run is about 90 cycles, so this only trips on a hang
   initial begin
      #100000;
      n_errors++;
      report_and_stop();
   end
endmodule
